// >>> hw/thermal_alarm_pkg.sv
package thermal_alarm_pkg;

    // Register addresses as seen on the serial management bus.
    localparam logic [7:0] addr_alarm_flags = 8'h02;
    localparam logic [7:0] addr_remote_low_limit_frac = 8'h14;
    localparam logic [7:0] addr_alarm_suppress = 8'h16;
    localparam logic [7:0] addr_critical_limit = 8'h19;
    localparam logic [7:0] addr_critical_hysteresis = 8'h21;
    localparam logic [7:0] addr_filter_and_comparator = 8'hbf;

    // Power-up values.
    localparam logic [7:0] critical_limit_reset = 8'h55;
    localparam logic [7:0] critical_hysteresis_reset = 8'h0a;
    localparam logic [7:0] suppress_reset = 8'h00;
    localparam logic [2:0] frac_reset = 3'h0;
    localparam logic [1:0] filter_reset = 2'h0;
    localparam logic comparator_reset = 1'b0;
    localparam logic [7:0] read_data_reset = 8'h00;

    // Status bit positions.
    localparam int bit_busy = 7;
    localparam int bit_local_high = 6;
    localparam int bit_unused = 5;
    localparam int bit_remote_high = 4;
    localparam int bit_remote_low = 3;
    localparam int bit_diode_fault = 2;
    localparam int bit_critical = 1;
    localparam int bit_tach = 0;

    // Status bits that are latched alarms.
    localparam logic [7:0] latched_alarm_bits = 8'h5f;
    // Alarms that may drive the alert pin: no fault, no tachometer, no busy.
    localparam logic [7:0] pin_alert_sources = 8'h5a;
    // Suppress register layout: writable bits and bits fixed at one.
    localparam logic [7:0] suppress_writable = 8'h5b;
    localparam logic [7:0] suppress_fixed_ones = 8'ha4;

    // Remote low fraction field occupies bits 7:5.
    localparam int frac_lsb = 5;
    localparam int frac_msb = 7;
    localparam logic [4:0] frac_pad = 5'h00;

    // Filter and comparator register fields.
    localparam int filter_lsb = 1;
    localparam int filter_msb = 2;
    localparam int comparator_bit = 0;
    localparam logic [4:0] filter_pad = 5'h00;

    // Filter select encodings.
    localparam logic [1:0] filter_code_off = 2'h0;
    localparam logic [1:0] filter_code_max = 2'h3;

    // Width used for the signed hysteresis threshold.
    localparam int threshold_width = 10;

endpackage

// >>> hw/alarm_latch.sv
`timescale 1ns/10ps
`default_nettype none

module alarm_latch
    import thermal_alarm_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Live condition and the read that may clear it.
    input wire logic condition,
    input wire logic read_clear,
    // Latched flag.
    output logic flag
);

    typedef struct packed {
        logic flag;
    } state_type;

    state_type state;
    state_type next_state;

    // A live condition always wins over a read, so an event in the read cycle is kept.
    always_comb begin
        next_state = state;
        next_state.flag = condition | (state.flag & ~read_clear);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state.flag <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign flag = state.flag;

endmodule

`default_nettype wire

// >>> hw/critical_tracker.sv
`timescale 1ns/10ps
`default_nettype none

module critical_tracker
    import thermal_alarm_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Remote integer reading, limit and hysteresis.
    input wire logic [7:0] remote_temperature,
    input wire logic [7:0] limit,
    input wire logic [7:0] hysteresis,
    // Critical condition with hysteresis applied.
    output logic critical_temperature
);

    typedef struct packed {
        logic active;
    } state_type;

    state_type state;
    state_type next_state;
    logic signed [threshold_width-1:0] temp_wide;
    logic signed [threshold_width-1:0] limit_wide;
    logic signed [threshold_width-1:0] release_level;

    // Widen before subtracting so a low limit minus a large hysteresis cannot wrap.
    assign temp_wide = {{(threshold_width-8){remote_temperature[7]}}, remote_temperature};
    assign limit_wide = {{(threshold_width-8){limit[7]}}, limit};
    assign release_level = limit_wide - $signed({{(threshold_width-8){1'b0}}, hysteresis});

    // Set above the limit; once set, hold until the reading drops below the release level.
    always_comb begin
        next_state = state;
        if (temp_wide > limit_wide) begin
            next_state.active = 1'b1;
        end else if (temp_wide < release_level) begin
            next_state.active = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state.active <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign critical_temperature = state.active;

endmodule

`default_nettype wire

// >>> hw/thermal_alarm_status_mask.sv
`timescale 1ns/10ps
`default_nettype none

module thermal_alarm_status_mask
    import thermal_alarm_pkg::*;
(
    // Clock and reset; reset stands for power-up.
    input wire logic clk,
    input wire logic rst,
    // Register port from the serial management bus engine.
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Limit override control from the configuration register.
    input wire logic critical_limit_unlock,
    // Live measurements and comparison results from the converter side.
    input wire logic [7:0] remote_temperature,
    input wire logic conversion_busy,
    input wire logic local_high_over,
    input wire logic remote_high_over,
    input wire logic remote_low_under,
    input wire logic diode_fault,
    input wire logic tach_over,
    // Settings handed to the converter and comparator logic.
    output logic [7:0] critical_limit_value,
    output logic [2:0] remote_low_fraction,
    output logic filter_enabled,
    output logic filter_heavy,
    output logic comparator_mode,
    output logic critical_temperature,
    // Open-drain alert pin: enable low pulls the pin low.
    output logic alert_out,
    output logic alert_oe_n
);

    // Everything the block stores, except the critical tracker's state, lives in this one record. The alarm flags are a
    // second exception: each sits in its own latch so the set-wins rule is written once.
    // Reset of the record models power-up, including the one-shot limit rewrite.
    typedef struct packed {
        logic [7:0] critical_limit;
        logic limit_rewritten;
        logic [7:0] critical_hysteresis;
        logic [7:0] suppress;
        logic [2:0] frac;
        logic [1:0] filter;
        logic comparator;
        logic alert_drive;
        logic [7:0] rdata;
        logic rvalid;
    } state_type;

    state_type state;
    state_type next_state;

    // Alarm conditions and latched flags by status bit position.
    logic [7:0] conditions;
    logic [7:0] flags;
    logic crit_active;

    // Read-side views of the registers.
    logic [7:0] status_view;
    logic [7:0] suppress_view;
    logic [7:0] filter_view;
    logic [7:0] frac_view;
    logic [7:0] read_view;

    // Decoded bus strobes.
    logic status_read;
    logic hit_limit;
    logic limit_accept;
    logic write_frac;
    logic write_suppress;
    logic write_hysteresis;
    logic write_filter;

    // Alert terms before the pin register.
    logic [7:0] latched_terms;
    logic [7:0] live_terms;
    logic latched_alert;
    logic live_alert;

    // Apart from reset, reading the status register is the only event that may clear flags.
    assign status_read = reg_read & (reg_addr == addr_alarm_flags);
    assign hit_limit = reg_write & (reg_addr == addr_critical_limit);

    // Write strobes per register. Writes to the status register or to an unmapped
    // address match none of them and are dropped without side effects.
    assign write_frac = reg_write & (reg_addr == addr_remote_low_limit_frac);
    assign write_suppress = reg_write & (reg_addr == addr_alarm_suppress);
    assign write_hysteresis = reg_write & (reg_addr == addr_critical_hysteresis);
    assign write_filter = reg_write & (reg_addr == addr_filter_and_comparator);

    // The limit takes one write per power-up, and only while the override is set.
    // Once used, the override input no longer matters, so a stuck override bit
    // cannot let the limit drift later.
    assign limit_accept = hit_limit & critical_limit_unlock & ~state.limit_rewritten;

    // The critical condition carries hysteresis, so it lives in its own tracker.
    // It compares the live reading with the stored limit, so a limit rewrite takes
    // effect on the very next clock without waiting for a new conversion.
    critical_tracker u_critical (
        .clk(clk),
        .rst(rst),
        .remote_temperature(remote_temperature),
        .limit(state.critical_limit),
        .hysteresis(state.critical_hysteresis),
        .critical_temperature(crit_active)
    );

    // The converter side hands over finished comparisons as levels; only the critical
    // condition is formed here, because it needs the stored limit and hysteresis.
    // Live conditions by status bit position; busy and the unused bit are not latched.
    always_comb begin
        conditions = 8'h00;
        conditions[bit_local_high] = local_high_over;
        conditions[bit_remote_high] = remote_high_over;
        conditions[bit_remote_low] = remote_low_under;
        conditions[bit_diode_fault] = diode_fault;
        conditions[bit_critical] = crit_active;
        conditions[bit_tach] = tach_over;
    end

    // One sticky latch per alarm bit; other positions stay zero. The mask does not
    // gate latching, so a masked alarm can still be found by polling the status.
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_flag
            if (latched_alarm_bits[i]) begin : g_latch
                alarm_latch u_latch (
                    .clk(clk),
                    .rst(rst),
                    .condition(conditions[i]),
                    .read_clear(status_read),
                    .flag(flags[i])
                );
            end else begin : g_none
                assign flags[i] = 1'b0;
            end
        end
    endgenerate

    // Status view: busy is live, bit 5 is forced to zero.
    // Busy is not a latched alarm, so a read never clears it.
    always_comb begin
        status_view = flags;
        status_view[bit_busy] = conversion_busy;
        status_view[bit_unused] = 1'b0;
    end

    // Unused suppress bits read as one whatever was written.
    // The filter and fraction views pad their spare bits with zeros.
    assign suppress_view = (state.suppress & suppress_writable) | suppress_fixed_ones;
    assign filter_view = {filter_pad, state.filter, state.comparator};
    assign frac_view = {state.frac, frac_pad};

    // Masked alert terms. Fault, busy and tachometer never reach the pin, since a
    // tachometer alarm means the pin is acting as the tachometer input.
    assign latched_terms = flags & ~state.suppress & pin_alert_sources;
    assign live_terms = conditions & ~state.suppress & pin_alert_sources;

    // Any remaining term asks for the pin.
    assign latched_alert = |latched_terms;
    assign live_alert = |live_terms;

    // Read data multiplexer. Status is taken before the clear that the same read
    // causes, so the host always sees the alarm that it is about to acknowledge.
    // A register written in the same cycle as it is read returns its old value.
    always_comb begin
        read_view = read_data_reset;
        case (reg_addr)
            addr_alarm_flags: begin
                read_view = status_view;
            end
            addr_remote_low_limit_frac: begin
                read_view = frac_view;
            end
            addr_alarm_suppress: begin
                read_view = suppress_view;
            end
            addr_critical_limit: begin
                read_view = state.critical_limit;
            end
            addr_critical_hysteresis: begin
                read_view = state.critical_hysteresis;
            end
            addr_filter_and_comparator: begin
                read_view = filter_view;
            end
            default: begin
                // Unmapped addresses read as zero rather than aliasing a register.
                read_view = read_data_reset;
            end
        endcase
    end

    // Next-state logic for every stored field. Each configuration field changes only on its own
    // write strobe, so a stray address can never disturb another register.
    always_comb begin
        next_state = state;
        // Read valid is a one-cycle answer to the read strobe.
        next_state.rvalid = reg_read;
        // The remote low fraction keeps bits 7:5 only; the low bits read back as zero.
        if (write_frac) begin
            next_state.frac = reg_wdata[frac_msb:frac_lsb];
        end
        // Only the alarm mask bits are stored; the spare bits are forced to one on read.
        if (write_suppress) begin
            next_state.suppress = reg_wdata & suppress_writable;
        end
        // Hysteresis is a plain byte with no write protection.
        if (write_hysteresis) begin
            next_state.critical_hysteresis = reg_wdata;
        end
        // Bits 7:3 are dropped so they always read back as zero.
        if (write_filter) begin
            next_state.filter = reg_wdata[filter_msb:filter_lsb];
            next_state.comparator = reg_wdata[comparator_bit];
        end
        // A single rewrite is allowed per power-up.
        if (limit_accept) begin
            next_state.critical_limit = reg_wdata;
            next_state.limit_rewritten = 1'b1;
        end
        // Read data holds its last value until the next read.
        if (reg_read) begin
            next_state.rdata = read_view;
        end
        // Comparator mode follows live conditions; normal mode follows latched flags.
        // Either way the pin lags its term by one register stage, which keeps the
        // open-drain enable free of decode glitches.
        if (state.comparator) begin
            next_state.alert_drive = live_alert;
        end else begin
            next_state.alert_drive = latched_alert;
        end
    end

    // Reset stands in for power-up, so it also rearms the one-time limit rewrite.
    // The flag latches and the critical tracker share this reset, so a reset in
    // mid-run clears every alarm together with the registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            // Stored registers take their power-up values.
            state.critical_limit <= critical_limit_reset;
            state.limit_rewritten <= 1'b0;
            state.critical_hysteresis <= critical_hysteresis_reset;
            state.suppress <= suppress_reset;
            state.frac <= frac_reset;
            state.filter <= filter_reset;
            state.comparator <= comparator_reset;
            // Pin released and bus answer idle.
            state.alert_drive <= 1'b0;
            state.rdata <= read_data_reset;
            state.rvalid <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs toward the bus engine and the rest of the sensor.
    assign reg_rdata = state.rdata;
    assign reg_rvalid = state.rvalid;

    // Settings toward the converter. The filter code is decoded here, so the
    // converter sees two plain enables and never has to know the encoding.
    assign critical_limit_value = state.critical_limit;
    assign remote_low_fraction = state.frac;
    assign filter_enabled = (state.filter != filter_code_off);
    assign filter_heavy = (state.filter == filter_code_max);
    assign comparator_mode = state.comparator;

    // The critical state leaves exactly as the tracker holds it, hysteresis applied.
    assign critical_temperature = crit_active;

    // The pin is only ever pulled low, never driven high; the pull-up on the board
    // gives the released level. The data stays low and only the enable moves, so
    // the pin cannot flash high while the alert changes.
    assign alert_out = 1'b0;
    assign alert_oe_n = ~state.alert_drive;

endmodule

`default_nettype wire

// >>> tb/alert_host.sv
`timescale 1ns/10ps
`default_nettype none

// Host side of the open-drain alert line with its pull-up resistor.
module alert_host (
    // Pin as driven by the device.
    input wire logic alert_out,
    input wire logic alert_oe_n,
    // Level the host senses.
    output logic alert_line
);
    // The pull-up wins whenever the device lets go, so a released pin reads one.
    assign alert_line = alert_oe_n ? 1'b1 : alert_out;
endmodule

`default_nettype wire

// >>> tb/thermal_alarm_chk.sv
`timescale 1ns/10ps
`default_nettype none

module thermal_alarm_chk (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Live inputs.
    input wire logic critical_limit_unlock,
    input wire logic [7:0] remote_temperature,
    input wire logic conversion_busy,
    input wire logic local_high_over,
    input wire logic remote_high_over,
    input wire logic remote_low_under,
    input wire logic diode_fault,
    input wire logic tach_over,
    // Outputs.
    input wire logic [7:0] critical_limit_value,
    input wire logic [2:0] remote_low_fraction,
    input wire logic filter_enabled,
    input wire logic filter_heavy,
    input wire logic comparator_mode,
    input wire logic critical_temperature,
    input wire logic alert_out,
    input wire logic alert_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Limit, status, suppress, critical and comparator relations.
    chk_limit_powerup: assert property ($fell(rst) |-> critical_limit_value == 8'h55)
        else $error("critical limit not at power-up value");
    chk_limit_guarded: assert property ($changed(critical_limit_value) |->
        $past(reg_write && reg_addr == 8'h19 && critical_limit_unlock))
        else $error("critical limit changed without unlocked write");
    chk_status_spare: assert property (reg_read && reg_addr == 8'h02 |=> reg_rdata[5] == 1'b0)
        else $error("status spare bit not zero");
    chk_busy_live: assert property (reg_read && reg_addr == 8'h02 |=>
        reg_rdata[7] == $past(conversion_busy))
        else $error("busy bit does not follow converter");
    chk_suppress_ones: assert property (reg_read && reg_addr == 8'h16 |=>
        (reg_rdata & 8'ha4) == 8'ha4)
        else $error("suppress spare bits not one");
    chk_crit_rise: assert property ($signed(remote_temperature) > $signed(critical_limit_value)
        |=> critical_temperature)
        else $error("critical not raised above limit");
    chk_crit_hold: assert property (critical_temperature &&
        $signed(remote_temperature) >= $signed(critical_limit_value) |=> critical_temperature)
        else $error("critical dropped too early");
    chk_comp_release: assert property (comparator_mode && !(local_high_over || remote_high_over
        || remote_low_under || critical_temperature) |=> alert_oe_n)
        else $error("comparator alert held without condition");

    // Main scenarios reached.
    cover property (!alert_oe_n ##1 alert_oe_n);
    cover property (comparator_mode && !alert_oe_n);
    cover property ($changed(critical_limit_value));
endmodule

bind thermal_alarm_status_mask thermal_alarm_chk chk (.*);

`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic unlock = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] temp = 8'h00;
    logic [7:0] cond = 8'h00;
    logic [7:0] reg_rdata;
    logic [7:0] limit;
    logic [7:0] srcs [3] = '{8'h40, 8'h10, 8'h08};
    logic [2:0] frac;
    logic reg_rvalid, f_en, f_hv, cmp, crit, a_out, a_oe_n, alert_line;
    int failures = 0;
    int num_checks = 0;

    thermal_alarm_status_mask dut (.clk(clk), .rst(rst), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .critical_limit_unlock(unlock), .remote_temperature(temp), .conversion_busy(cond[7]),
        .local_high_over(cond[6]), .remote_high_over(cond[4]), .remote_low_under(cond[3]),
        .diode_fault(cond[2]), .tach_over(cond[0]), .critical_limit_value(limit),
        .remote_low_fraction(frac), .filter_enabled(f_en), .filter_heavy(f_hv),
        .comparator_mode(cmp), .critical_temperature(crit), .alert_out(a_out), .alert_oe_n(a_oe_n));
    alert_host host (.alert_out(a_out), .alert_oe_n(a_oe_n), .alert_line(alert_line));

    // Clock of 5 ns.
    always #2.5 clk = ~clk;

    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Inputs always move 1 ns after an edge so sampling never races.
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] v);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        tick(1);
        reg_write = 1'b0;
        tick(1);
    endtask

    // The answer stands for one cycle only, so it is sampled right after the read edge.
    task rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        reg_read = 1'b1;
        reg_addr = a;
        tick(1);
        reg_read = 1'b0;
        check("rvalid", {7'h0, reg_rvalid}, 8'h01);
        check(name, reg_rdata, exp);
        tick(1);
    endtask

    // One-cycle condition pulse, gone again before any read.
    task pulse(input logic [7:0] c);
        cond = c;
        tick(1);
        cond = 8'h00;
        tick(1);
    endtask

    task wrap_up;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog, far beyond the 126 cycles the sequence needs.
    initial begin
        #20000;
        failures++;
        wrap_up;
    end

    initial begin
        tick(2);
        rst = 1'b0;
        // Power-up values and an unmapped read.
        rd(8'h19, 8'h55, "limit");
        rd(8'h21, 8'h0a, "hysteresis");
        rd(8'h16, 8'ha4, "suppress");
        rd(8'h14, 8'h00, "fraction");
        rd(8'h02, 8'h00, "status");
        rd(8'h30, 8'h00, "unmapped");
        // The limit takes exactly one rewrite, and only when unlocked.
        wr(8'h19, 8'h60);
        rd(8'h19, 8'h55, "locked limit");
        unlock = 1'b1;
        wr(8'h19, 8'h5a);
        rd(8'h19, 8'h5a, "new limit");
        wr(8'h19, 8'h70);
        rd(8'h19, 8'h5a, "second rewrite");
        check("limit port", limit, 8'h5a);
        unlock = 1'b0;
        // Alert-raising alarms latch, drive the pin and clear on read.
        for (int k = 0; k < 3; k++) begin
            pulse(srcs[k]);
            check("alert on", {7'h0, alert_line}, 8'h00);
            rd(8'h02, srcs[k], "latched");
            check("alert off", {7'h0, alert_line}, 8'h01);
            rd(8'h02, 8'h00, "cleared");
        end
        // Fault, tachometer and busy never pull the pin.
        pulse(8'h05);
        check("fault alert", {7'h0, alert_line}, 8'h01);
        rd(8'h02, 8'h05, "fault tach");
        cond = 8'h80;
        tick(1);
        check("busy alert", {7'h0, alert_line}, 8'h01);
        rd(8'h02, 8'h80, "busy");
        cond = 8'h00;
        rd(8'h02, 8'h00, "idle");
        // Suppressed alarms still latch but leave the pin alone.
        wr(8'h16, 8'hff);
        rd(8'h16, 8'hff, "suppress all");
        pulse(8'h58);
        check("masked alert", {7'h0, alert_line}, 8'h01);
        rd(8'h02, 8'h58, "masked flags");
        wr(8'h16, 8'h00);
        // Critical with hysteresis: limit 0x5a, hysteresis 0x0a.
        temp = 8'h5b;
        tick(3);
        check("critical", {7'h0, crit}, 8'h01);
        check("critical alert", {7'h0, alert_line}, 8'h00);
        temp = 8'h50;
        tick(2);
        check("hysteresis edge", {7'h0, crit}, 8'h01);
        rd(8'h02, 8'h02, "critical flag");
        temp = 8'h4f;
        tick(2);
        check("critical gone", {7'h0, crit}, 8'h00);
        rd(8'h02, 8'h02, "still latched");
        rd(8'h02, 8'h00, "now cleared");
        // A rewritten hysteresis moves the release point to 0x55.
        wr(8'h21, 8'h05);
        rd(8'h21, 8'h05, "new hysteresis");
        temp = 8'h5b;
        tick(2);
        temp = 8'h55;
        tick(2);
        check("new release edge", {7'h0, crit}, 8'h01);
        temp = 8'h54;
        tick(2);
        check("new release", {7'h0, crit}, 8'h00);
        rd(8'h02, 8'h02, "critical again");
        rd(8'h02, 8'h00, "critical cleared");
        // Comparator mode follows the live condition.
        wr(8'hbf, 8'h01);
        cond = 8'h10;
        tick(2);
        check("comparator on", {7'h0, alert_line}, 8'h00);
        cond = 8'h00;
        tick(2);
        check("comparator off", {7'h0, alert_line}, 8'h01);
        rd(8'h02, 8'h10, "comparator flag");
        // Every filter code.
        for (int c = 0; c < 4; c++) begin
            wr(8'hbf, 8'(c << 1));
            check("filter on", {7'h0, f_en}, 8'(c != 0));
            check("filter heavy", {7'h0, f_hv}, 8'(c == 3));
        end
        wr(8'hbf, 8'hff);
        rd(8'hbf, 8'h07, "filter reg");
        check("comparator bit", {7'h0, cmp}, 8'h01);
        wr(8'h14, 8'hff);
        rd(8'h14, 8'he0, "fraction reg");
        check("fraction port", {5'h0, frac}, 8'h07);
        // A reset in mid-run stands for a power cycle and rearms the single rewrite.
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        rd(8'h19, 8'h55, "limit after reset");
        rd(8'h21, 8'h0a, "hysteresis after reset");
        rd(8'hbf, 8'h00, "filter after reset");
        check("fraction reset", {5'h0, frac}, 8'h00);
        unlock = 1'b1;
        wr(8'h19, 8'h64);
        rd(8'h19, 8'h64, "rearmed limit");
        unlock = 1'b0;
        wrap_up;
    end
endmodule

`default_nettype wire
